// >>> bench/hsp_handler_model.sv
module hsp_handler_model
  import hsp_pkg::*;
(
  input  wire logic        clock,
  input  wire hsp_drive_t  handler_drive,
  input  wire logic [11:0] handler_level,
  output logic             start_n,
  output logic      [11:0] line,
  output int               cyc,
  output int               t_fall,
  output logic      [9:0]  latched
);
  timeunit 1ns;
  timeprecision 1ps;

  // pull-ups: a released line reads high
  assign line = (~handler_drive & handler_level) | handler_drive;

  // cycle count, handler idles with start high
  initial begin
    cyc = 0;
    start_n = 1'b1;
  end
  always @(posedge clock) cyc <= cyc + 1;

  // bin pattern latched as end of test falls
  always @(negedge line[10]) latched <= line[9:0];

  // biased-part fixture once the result stands: bias off, 10 ohm discharge, then short
  logic [2:0] fixture = 3'b100;  // bias, discharge, short
  always @(negedge line[10]) begin
    fixture <= 3'b000;
    @(posedge clock);
    fixture <= 3'b010;
    @(posedge clock);
    fixture <= 3'b001;
    @(negedge start_n);
    fixture <= 3'b100;
  end

  //////////////////////////////////////////////////////////////////////
  // each level kept for 1 us of clock
  task automatic hold(logic v);
    start_n <= v;
    repeat (200) @(posedge clock);
  endtask

  // bounces first, then settles low; scaled ms shrink the 20 ms budget
  task automatic press(int bounces);
    @(posedge clock);
    repeat (bounces) begin
      hold(1'b0);
      hold(1'b1);
    end
    t_fall = cyc;
    hold(1'b0);
    start_n <= 1'b1;
  endtask
endmodule  // hsp_handler_model

// >>> bench/tb.sv
module tb
  import hsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 5;
  logic        clock;
  logic        reset_n;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic        start_n;
  logic [11:0] handler_level;
  logic [11:0] line;
  logic [9:0]  latched;
  hsp_drive_t  handler_drive;
  int          fails;
  int          checks_done;
  int          cyc;
  int          t_fall;

  hsp_handler_port #(.CYCLES_PER_MS(CPM)) i_hsp_handler_port (.clock(clock), .reset_n(reset_n),
    .start_n(start_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .handler_drive(handler_drive), .handler_level(handler_level));
  hsp_handler_model i_hsp_handler_model (.clock(clock), .handler_drive(handler_drive),
    .handler_level(handler_level), .start_n(start_n), .line(line), .cyc(cyc), .t_fall(t_fall),
    .latched(latched));

  //////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rng(int v, int lo, int hi);
    checks_done++;
    if (v < lo || v > hi) begin
      fails++;
      $display("mismatch at %0t: %0d cycles not in %0d..%0d", $time, v, lo, hi);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // read data only stand in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    rd_val = reg_rdata;
  endtask

  // bounded wait until a masked line is pulled low
  task automatic wait_low(logic [11:0] mask, output int t);
    int n;
    n = 0;
    while ((line & mask) === mask && n < 20000) begin
      @(negedge clock);
      n++;
    end
    t = cyc;
  endtask

  // one full start, acquire, sort, end-of-test sequence
  task automatic measure(logic [4:0] cfg, logic [3:0] cls, int acq, int bounces);
    int ta;
    int tn;
    int te;
    logic [3:0] ec;
    int extra;
    ec = (cls > 4'h9) ? 4'h9 : cls;
    // every averaged round after the first costs one reload cycle
    extra = cfg[0] ? int'(AVG_ROUNDS) - 1 : 0;
    wr(REG_CONTROL, {27'h0, cfg});
    wr(REG_CLASS, {28'h0, cls});
    i_hsp_handler_model.press(bounces);
    cmp({20'h0, line}, 32'hfff);
    rd(REG_STATUS);
    cmp(rd_val & 32'h0000000f, 32'h1);
    wait_low(12'h800, ta);
    cmp_rng(ta - t_fall, acq + 1 + extra, acq + 5 + extra);
    cmp({20'h0, line}, 32'h7ff);
    wait_low(12'h3ff, tn);
    cmp_rng(tn - ta, 10 * CPM, 50 * CPM);
    cmp({20'h0, line}, {20'h0, 2'b01, ~(10'h1 << ec)});
    wait_low(12'h400, te);
    cmp_rng(te - tn, END_GAP_CYCLES - 2, END_GAP_CYCLES + 2);
    cmp({22'h0, latched}, {22'h0, ~(10'h1 << ec)});
    rd(REG_STATUS);
    cmp(rd_val, {24'h0, ec, 4'he});
    repeat (300) @(negedge clock);
    cmp({20'h0, line}, {20'h0, 2'b00, ~(10'h1 << ec)});
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic check_after_reset();
    cmp({20'h0, line}, 32'hfff);
    rd(REG_CONTROL);
    cmp(rd_val, {27'h0, CONTROL_RESET});
    rd(REG_CLASS);
    cmp(rd_val, {28'h0, CLASS_RESET});
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c);
    cmp(rd_val, 32'h0);
    wr(REG_STATUS, 32'hff);
    rd(REG_STATUS);
    cmp(rd_val & 32'hffffff0f, 32'h0);
    wr(REG_CONTROL, 32'hffffffff);
    rd(REG_CONTROL);
    cmp(rd_val, 32'h1f);
    cmp({20'h0, line}, 32'hfff);
  endtask

  // every frequency, line and speed pairing, each with its own class
  task automatic check_timing_table();
    int ms[12] = '{255, 425, 710, 240, 400, 660, 160, 335, 635, 145, 310, 585};
    for (int i = 0; i < 12; i++) begin
      measure({(i == 11) ? 2'd3 : 2'(i % 3), 1'(i / 3 % 2), 1'(i / 6), 1'b0}, 4'(i), ms[i] * CPM, 0);
    end
  endtask

  task automatic check_averaged_bounce();
    measure(5'h07, 4'h5, 10 * 145 * CPM, 1);
  endtask

  //////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // main sequence
  initial begin
    fails = 0;
    checks_done = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    check_after_reset();
    check_timing_table();
    check_averaged_bounce();
    complete_run();
  end

  // run needs about 52k cycles; cut a hang well before 100k
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    complete_run();
  end
endmodule  // tb

// >>> hdl/hsp_bin_decoder.sv
module hsp_bin_decoder
  import hsp_pkg::*;
(
  input  wire logic [3:0] sort_class,
  output logic      [9:0] bin_oe_n
);

  logic [3:0] clamped;

  ////////////////////////////////////////////////////////////////////////////
  // out of range classes fall into the catch-all default line 9
  always_comb begin
    clamped  = (sort_class > CLASS_LAST) ? CLASS_LAST : sort_class;
    bin_oe_n = ~(10'h001 << clamped);
  end

endmodule // hsp_bin_decoder

// >>> hdl/hsp_handler_port.sv
// Overview of operation
// - start low begins single or averaged measurement
// - all handler outputs open-collector, active low
// - bounces restart; settle low within 20 ms
// - acquisition done pulled low after acquisition
// - one bin line 10 to 50 ms later
// - other bin lines stay released
// - end-of-test low few microseconds after bin
// - outputs held low until next start
// - class 0 reject, 1-8 accept, 9 default
// - timing follows frequency, line and speed
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
module hsp_handler_port
  import hsp_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        start_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  output hsp_drive_t       handler_drive,
  output logic      [11:0] handler_level
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACQUIRE,
    ST_SORT_WAIT,
    ST_END_WAIT,
    ST_HOLD
  } hsp_state_t;

  hsp_state_t  state;
  hsp_config_t config_q;
  logic [3:0]  class_q;
  logic [3:0]  reported_class;
  logic        start_q;
  logic        start_fall;
  logic [3:0]  rounds_left;
  logic [31:0] acq_cycles;
  logic        timer_load;
  logic [31:0] timer_value;
  logic        timer_expired;
  logic [9:0]  decoded_bin_oe_n;
  logic [31:0] run_cnt;
  logic [31:0] gap_cnt;
  logic        bin_any;
  logic [31:0] end_gap_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // start edge, input taken as synchronous
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_q <= 1'b1;
    end else begin
      start_q <= start_n;
    end
  end

  // every falling edge restarts, so a bouncing contact just restarts
  assign start_fall = start_q & ~start_n;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      config_q <= hsp_config_t'(CONTROL_RESET);
      class_q  <= CLASS_RESET;
    end else if (reg_write) begin
      if (reg_addr == REG_CONTROL) begin
        config_q <= hsp_config_t'(reg_wdata[4:0]);
      end
      if (reg_addr == REG_CLASS) begin
        class_q <= reg_wdata[3:0];
      end
    end
  end

  // register reads, data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        REG_CONTROL: reg_rdata <= {27'h0, config_q};
        REG_CLASS:   reg_rdata <= {28'h0, class_q};
        REG_STATUS:  reg_rdata <= {24'h0, reported_class, ~handler_drive.end_of_test_flag_oe_n, bin_any,
                                   ~handler_drive.acquisition_done_flag_oe_n, (state != ST_IDLE && state != ST_HOLD)};
        default:     reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acquisition length from the measurement conditions
  // slowest row at the real clock is 142M cycles, well inside 32 bits
  assign acq_cycles = 32'(hsp_acq_ms(config_q)) * 32'(CYCLES_PER_MS);

  // timer reloads: acquisition, sort delay, end-of-test gap
  always_comb begin
    timer_load  = 1'b0;
    timer_value = acq_cycles;
    if (start_fall) begin
      timer_load = 1'b1;
    end else if (timer_expired) begin
      unique case (state)
        ST_ACQUIRE: begin
          timer_load  = 1'b1;
          timer_value = (rounds_left > 4'h1) ? acq_cycles : 32'(SORT_DELAY_MS * CYCLES_PER_MS);
        end
        ST_SORT_WAIT: begin
          timer_load  = 1'b1;
          timer_value = 32'(END_GAP_CYCLES);
        end
        default: timer_load = 1'b0;
      endcase
    end
  end

  // one shared timer: the three phases never overlap
  hsp_interval_timer i_hsp_interval_timer (
    .clock      (clock),
    .reset_n    (reset_n),
    .load       (timer_load),
    .load_value (timer_value),
    .expired    (timer_expired),
    .running    ()
  );

  hsp_bin_decoder i_hsp_bin_decoder (
    .sort_class (class_q),
    .bin_oe_n   (decoded_bin_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // measurement sequence
  // each averaged round reload costs one cycle, negligible at the real clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_IDLE;
      rounds_left <= 4'h0;
    end else if (start_fall) begin
      state       <= ST_ACQUIRE;
      rounds_left <= config_q.averaged ? 4'(AVG_ROUNDS) : 4'h1;
    end else if (timer_expired) begin
      unique case (state)
        ST_ACQUIRE: begin
          if (rounds_left > 4'h1) begin
            rounds_left <= rounds_left - 4'h1;
          end else begin
            state <= ST_SORT_WAIT;
          end
        end
        ST_SORT_WAIT: state <= ST_END_WAIT;
        ST_END_WAIT:  state <= ST_HOLD;
        default:      state <= state;
      endcase
    end
  end

  // handler lines; released on start, held low until the next one
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      handler_drive  <= DRIVE_RELEASED;
      reported_class <= CLASS_RESET;
    end else if (start_fall) begin
      handler_drive <= DRIVE_RELEASED;
    end else if (timer_expired) begin
      unique case (state)
        ST_ACQUIRE: begin
          if (rounds_left <= 4'h1) begin
            handler_drive.acquisition_done_flag_oe_n <= 1'b0;
          end
        end
        ST_SORT_WAIT: begin
          handler_drive.bin_oe_n <= decoded_bin_oe_n; // exactly one line
          reported_class         <= (class_q > CLASS_LAST) ? CLASS_LAST : class_q; // the line actually driven
        end
        ST_END_WAIT: handler_drive.end_of_test_flag_oe_n <= 1'b0;
        default: handler_drive <= handler_drive;
      endcase
    end
  end

  // open collector: pad level is always low, enables do the signalling
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      handler_level <= 12'h000;
    end else begin
      handler_level <= 12'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper counters for the checks below
  assign bin_any = ~&handler_drive.bin_oe_n;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_cnt <= 32'h0000_0000;
    end else if (start_fall) begin
      run_cnt <= 32'h0000_0000;
    end else if (run_cnt != 32'hffff_ffff) begin
      run_cnt <= run_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt <= 32'h0000_0000;
    end else if (!handler_drive.acquisition_done_flag_oe_n && !bin_any) begin
      gap_cnt <= gap_cnt + 32'h0000_0001;
    end else begin
      gap_cnt <= 32'h0000_0000;
    end
  end

  // cycles the sort line has stood without end-of-test, bounds the few-microsecond gap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      end_gap_cnt <= 32'h0000_0000;
    end else if (bin_any && handler_drive.end_of_test_flag_oe_n) begin
      end_gap_cnt <= end_gap_cnt + 32'h0000_0001;
    end else begin
      end_gap_cnt <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_start_begins_run: assert property (@(posedge clock) disable iff (!reset_n)
    start_fall |=> state == ST_ACQUIRE ##1 (state == ST_ACQUIRE || start_fall || $past(start_fall)))
    else $error("start edge did not begin a measurement");

  a_lines_pull_low: assert property (@(posedge clock) disable iff (!reset_n)
    (handler_drive != DRIVE_RELEASED) |-> handler_level == 12'h000)
    else $error("handler pad driven high");

  a_acq_after_run: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(handler_drive.acquisition_done_flag_oe_n) |-> run_cnt >= acq_cycles)
    else $error("acquisition done reported too early");

  a_sort_delay_window: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(bin_any) |-> !handler_drive.acquisition_done_flag_oe_n
      && gap_cnt >= 32'(SORT_MIN_MS * CYCLES_PER_MS) && gap_cnt <= 32'(SORT_MAX_MS * CYCLES_PER_MS))
    else $error("sort line outside its delay window");

  a_single_bin_line: assert property (@(posedge clock) disable iff (!reset_n)
    bin_any |-> $onehot(~handler_drive.bin_oe_n))
    else $error("more than one sort line asserted");

  a_class_encoding: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(bin_any) |-> handler_drive.bin_oe_n[(reported_class > CLASS_LAST) ? CLASS_LAST : reported_class] == 1'b0)
    else $error("sort line does not match class");

  a_end_after_gap: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(handler_drive.end_of_test_flag_oe_n) |-> end_gap_cnt >= 32'(END_GAP_CYCLES)
      && end_gap_cnt <= 32'(END_GAP_CYCLES) + 32'h0000_0002)
    else $error("end of test not a few microseconds after sort line");

  a_end_within_gap: assert property (@(posedge clock) disable iff (!reset_n)
    (bin_any && handler_drive.end_of_test_flag_oe_n) |-> end_gap_cnt <= 32'(END_GAP_CYCLES) + 32'h0000_0002)
    else $error("end of test overdue after sort line");

  a_bin_needs_acq: assert property (@(posedge clock) disable iff (!reset_n)
    bin_any |-> !handler_drive.acquisition_done_flag_oe_n)
    else $error("sort line asserted before acquisition done");

  a_end_needs_bin: assert property (@(posedge clock) disable iff (!reset_n)
    !handler_drive.end_of_test_flag_oe_n |-> bin_any)
    else $error("end of test without a sort line");

  a_class_clamped: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(bin_any) |-> reported_class <= CLASS_LAST)
    else $error("reported class outside the ten lines");

  a_rdata_idle: assert property (@(posedge clock) disable iff (!reset_n)
    !$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  a_result_held: assert property (@(posedge clock) disable iff (!reset_n)
    (!handler_drive.end_of_test_flag_oe_n && !start_fall) |=> !handler_drive.end_of_test_flag_oe_n && bin_any
      && !handler_drive.acquisition_done_flag_oe_n)
    else $error("result released without a start");

  a_start_releases: assert property (@(posedge clock) disable iff (!reset_n)
    start_fall |=> handler_drive == DRIVE_RELEASED)
    else $error("start did not release the handler lines");

  a_idle_released: assert property (@(posedge clock) disable iff (!reset_n)
    state == ST_IDLE |-> handler_drive == DRIVE_RELEASED)
    else $error("handler line asserted before any result");

endmodule // hsp_handler_port

// >>> hdl/hsp_interval_timer.sv
module hsp_interval_timer
  import hsp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  output logic             expired,
  output logic             running
);

  logic [31:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // down counter, a zero load still takes one cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count   <= 32'h0000_0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (load) begin
      count   <= (load_value == 32'h0000_0000) ? 32'h0000_0001 : load_value;
      running <= 1'b1;
      expired <= 1'b0;
    end else if (running) begin
      count   <= count - 32'h0000_0001;
      expired <= (count == 32'h0000_0001);
      running <= (count != 32'h0000_0001);
    end else begin
      expired <= 1'b0;
    end
  end

endmodule // hsp_interval_timer

// >>> hdl/hsp_pkg.sv
package hsp_pkg;

  // clock and derived timing
  localparam int unsigned CLOCK_MHZ         = 200;
  localparam int unsigned CYCLES_PER_MS_DEF = CLOCK_MHZ * 1000;
  localparam int unsigned SORT_DELAY_MS     = 25;
  localparam int unsigned SORT_MIN_MS       = 10;
  localparam int unsigned SORT_MAX_MS       = 50;
  localparam int unsigned END_GAP_US        = 5;
  localparam int unsigned END_GAP_CYCLES    = END_GAP_US * CLOCK_MHZ;
  localparam int unsigned AVG_ROUNDS        = 10;
  localparam int unsigned START_MIN_US      = 1;
  localparam int unsigned BOUNCE_MAX_MS     = 20;

  // register map
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_CLASS   = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;

  // control field positions
  localparam int unsigned CTL_AVG_BIT   = 0;
  localparam int unsigned CTL_TFREQ_BIT = 1;
  localparam int unsigned CTL_LINE_BIT  = 2;
  localparam int unsigned CTL_SPEED_LO  = 3;

  // reset values
  localparam logic [4:0] CONTROL_RESET = 5'h00;
  localparam logic [3:0] CLASS_RESET   = 4'h9;
  localparam logic [3:0] CLASS_LAST    = 4'h9;

  typedef enum logic [1:0] {
    HSP_FAST,
    HSP_MEDIUM,
    HSP_SLOW,
    HSP_SLOW_ALT
  } hsp_speed_t;

  // msb first: speed [4:3], line [2], test frequency [1], averaged [0]
  typedef struct packed {
    hsp_speed_t speed;
    logic       line_60hz;
    logic       test_freq_high;
    logic       averaged;
  } hsp_config_t;

  // open-collector enables, low while the line is pulled low
  typedef struct packed {
    logic       acquisition_done_flag_oe_n;
    logic       end_of_test_flag_oe_n;
    logic [9:0] bin_oe_n;
  } hsp_drive_t;

  localparam hsp_drive_t DRIVE_RELEASED = '{1'b1, 1'b1, 10'h3ff};

  // start to acquisition-done time in ms for one acquisition
  function automatic logic [9:0] hsp_acq_ms(input hsp_config_t cfg);
    logic [1:0] row;
    logic [9:0] ms;
    row = {cfg.test_freq_high, cfg.line_60hz};
    ms  = 10'h000;
    unique case (row)
      2'b10: ms = (cfg.speed == HSP_FAST) ? 10'd160 : (cfg.speed == HSP_MEDIUM) ? 10'd335 : 10'd635;
      2'b11: ms = (cfg.speed == HSP_FAST) ? 10'd145 : (cfg.speed == HSP_MEDIUM) ? 10'd310 : 10'd585;
      2'b01: ms = (cfg.speed == HSP_FAST) ? 10'd240 : (cfg.speed == HSP_MEDIUM) ? 10'd400 : 10'd660;
      2'b00: ms = (cfg.speed == HSP_FAST) ? 10'd255 : (cfg.speed == HSP_MEDIUM) ? 10'd425 : 10'd710;
    endcase
    return ms;
  endfunction

endpackage
